// ---- core/ssienc_pkg.sv ----
// Package: constants and types for the serial absolute encoder port
package ssienc_pkg;
	// ==========================================================
	// Clock and timing
	localparam int unsigned MCLK_HZ             = 50000000;
	localparam int unsigned TIMEOUT_US          = 20;
	localparam int unsigned TIMEOUT_CYC         = (TIMEOUT_US * (MCLK_HZ / 1000000));
	localparam int unsigned AVAIL_MS            = 250;
	localparam int unsigned AVAIL_CYC           = AVAIL_MS * (MCLK_HZ / 1000);
	localparam int unsigned INPUT_QUAL_MS       = 5;
	localparam int unsigned INPUT_QUAL_CYC      = INPUT_QUAL_MS * (MCLK_HZ / 1000);
	// ==========================================================
	// Widths
	localparam int unsigned ST_BITS             = 16;
	localparam int unsigned MT_BITS             = 14;
	localparam int unsigned POS_BITS            = ST_BITS + MT_BITS;
	localparam int unsigned FRAME_BITS          = POS_BITS + 1;
	localparam int unsigned BITCNT_W            = 5;
	localparam int unsigned TMR_W               = 10;
	localparam int unsigned QUAL_W              = 28;
	// ==========================================================
	// Register bus map (byte addresses, word index in bits 3:2)
	localparam logic [3:0]  CTRL_ADDR           = 4'h0;
	localparam logic [3:0]  STEP_ADDR           = 4'h4;
	localparam logic [3:0]  POS_ADDR            = 4'h8;
	localparam logic [3:0]  STAT_ADDR           = 4'hc;
	// CTRL fields
	localparam int unsigned CTRL_BINARY_BIT     = 0;
	localparam int unsigned CTRL_SPECIAL_BIT    = 1;
	localparam int unsigned CTRL_INCR_EN_BIT    = 2;
	localparam int unsigned CTRL_PPR_LSB        = 4;
	localparam logic [31:0] CTRL_RESET          = 32'h0000_0000;
	// Incremental pulses per revolution selection
	typedef enum logic [1:0] {
		SSIENC_PPR_1024 = 2'h0,
		SSIENC_PPR_2048 = 2'h1,
		SSIENC_PPR_4096 = 2'h2
	} ssienc_ppr_t;
	// Link state, Gray coded along idle -> shift -> hold
	typedef enum logic [1:0] {
		SSIENC_IDLE  = 2'b00,
		SSIENC_SHIFT = 2'b01,
		SSIENC_HOLD  = 2'b11
	} ssienc_state_t;
endpackage

// ---- core/ssienc_link.sv ----
// Link side: serial frame shifter running on the controller's serial clock
`timescale 1ns/1ns
`default_nettype none
module ssienc_link
	import ssienc_pkg::*;
(
	input  wire logic                  sclk_in,      // Serial clock from controller
	input  wire logic                  rst_in,       // Asynchronous reset, high
	input  wire logic [FRAME_BITS-1:0] word_in,      // Encoded word, stable in core domain
	input  wire logic                  ready_in,     // Availability level, frozen in core domain
	output logic                       data_out,     // Serial data line
	output logic                       frame_tgl_out // Toggles at each frame latch
);
	// ==========================================================
	// Shift register
	logic [FRAME_BITS-1:0] shift_reg;
	logic [BITCNT_W-1:0]   cnt_reg;
	logic                  active_reg;

	// Latch on first falling edge, shift on rising edges; the core timeout
	// clears active through the link's asynchronous reset, so that edge counts are
	// bounded by frame length
	always_ff @(negedge sclk_in or posedge rst_in) begin
		if (rst_in) begin
			active_reg    <= 1'b0;
			frame_tgl_out <= 1'b0;
		end else if (!active_reg) begin
			active_reg    <= 1'b1;
			frame_tgl_out <= ~frame_tgl_out;
		end
	end

	// Word sampled at the rising edge after latch; the core holds it still
	always_ff @(posedge sclk_in or posedge rst_in) begin
		if (rst_in) begin
			shift_reg <= '0;
			cnt_reg   <= '0;
			data_out  <= 1'b1;
		end else if (cnt_reg == BITCNT_W'(0)) begin
			shift_reg <= {word_in[FRAME_BITS-2:0], 1'b0};
			data_out  <= ready_in ? word_in[FRAME_BITS-1] : 1'b0;
			cnt_reg   <= BITCNT_W'(1);
		end else if (cnt_reg < BITCNT_W'(FRAME_BITS)) begin
			shift_reg <= {shift_reg[FRAME_BITS-2:0], 1'b0};
			data_out  <= ready_in ? shift_reg[FRAME_BITS-1] : 1'b0;
			cnt_reg   <= cnt_reg + BITCNT_W'(1);
		end else begin
			data_out  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- core/ssienc_top.sv ----
// Top: serial absolute encoder port with position, direction, zero-set and A/B track
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ssienc_top
	import ssienc_pkg::*;
#(
	parameter int unsigned AVAIL_CYCLES = AVAIL_CYC,      // Power-up delay
	parameter int unsigned QUAL_CYCLES  = INPUT_QUAL_CYC  // Function input filter
)(
	input  wire logic                mclk_in,            // Core clock, 50 MHz
	input  wire logic                rst_in,             // Asynchronous reset, high
	input  wire logic                sclk_in,            // Serial clock from controller
	output logic                     sdata_out,          // Serial data line
	input  wire logic                dir_sel_n_in,       // Direction select, low = reverse
	input  wire logic                zero_set_in,        // Zero-set, high active
	input  wire logic                step_up_in,         // Sensor step, shaft ccw
	input  wire logic                step_dn_in,         // Sensor step, shaft cw
	output logic                     track_a_out,        // Incremental A
	output logic                     track_a_n_out,      // Incremental A complement
	output logic                     track_b_out,        // Incremental B
	output logic                     track_b_n_out,      // Incremental B complement
	input  wire logic [3:0]          avs_address,        // Avalon byte address
	input  wire logic                avs_read,           // Avalon read
	input  wire logic                avs_write,          // Avalon write
	input  wire logic [31:0]         avs_writedata,      // Avalon write data
	output logic [31:0]              avs_readdata,       // Avalon read data
	output logic                     avs_waitrequest     // Avalon wait
);
	// ==========================================================
	// Declarations
	logic [2:0]            sclk_sync_reg;
	logic [2:0]            dir_sync_reg;
	logic [2:0]            zero_sync_reg;
	logic                  sclk_filt_reg;
	logic                  dir_filt_reg;
	logic                  zero_filt_reg;
	logic [TMR_W-1:0]      tmr_reg;
	logic                  link_rst_reg;
	logic                  link_rst_n_reg;
	ssienc_state_t         state_reg;
	logic [QUAL_W-1:0]     avail_cnt_reg;
	logic                  ready_reg;
	logic [QUAL_W-1:0]     dir_cnt_reg;
	logic [QUAL_W-1:0]     zero_cnt_reg;
	logic                  dir_rev_reg;
	logic                  zero_done_reg;
	logic [POS_BITS-1:0]   raw_reg;
	logic [POS_BITS-1:0]   offset_reg;
	logic [POS_BITS-1:0]   pos_reg;
	logic [FRAME_BITS-1:0] word_reg;
	logic [31:0]           ctrl_reg;
	logic                  ack_reg;
	logic [2:0]            tgl_sync_reg;
	logic                  link_data;
	logic                  link_tgl;
	logic                  ready_link_reg;
	logic [1:0]            quad_reg;
	logic [11:0]           sub_reg;
	logic [11:0]           sub_max;
	logic                  frame_latch;

	// Binary to reflected Gray, used for the serial word
	function automatic logic [POS_BITS-1:0] to_gray(input logic [POS_BITS-1:0] b);
		to_gray = b ^ (b >> 1);
	endfunction

	// Three-stage synchroniser filter: change accepted when stages 2 and 3 agree
	function automatic logic filt_next(input logic [2:0] s, input logic cur);
		filt_next = (s[1] == s[2]) ? s[2] : cur;
	endfunction

	// ==========================================================
	// Input synchronisers
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sclk_sync_reg <= 3'h7;
			dir_sync_reg  <= 3'h7;
			zero_sync_reg <= 3'h0;
			tgl_sync_reg  <= 3'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
			dir_sync_reg  <= {dir_sync_reg[1:0], dir_sel_n_in};
			zero_sync_reg <= {zero_sync_reg[1:0], zero_set_in};
			tgl_sync_reg  <= {tgl_sync_reg[1:0], link_tgl};        // Frame toggle, status only
		end
	end

	// Glitch filter; one-cycle spikes never reach the edge detector
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sclk_filt_reg <= 1'b1;
			dir_filt_reg  <= 1'b1;
			zero_filt_reg <= 1'b0;
		end else begin
			sclk_filt_reg <= filt_next(sclk_sync_reg, sclk_filt_reg);
			dir_filt_reg  <= filt_next(dir_sync_reg, dir_filt_reg);
			zero_filt_reg <= filt_next(zero_sync_reg, zero_filt_reg);
		end
	end

	// ==========================================================
	// Frame timeout: restarted at every falling clock edge
	assign frame_latch = sclk_filt_reg & ~filt_next(sclk_sync_reg, sclk_filt_reg);

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg      <= SSIENC_IDLE;
			tmr_reg        <= '0;
			link_rst_reg   <= 1'b1;
			link_rst_n_reg <= 1'b0;
		end else begin
			link_rst_reg   <= 1'b0;
			link_rst_n_reg <= ~link_rst_reg;                       // Link reset, released on mclk
			unique case (state_reg)
				SSIENC_IDLE: begin
					if (frame_latch) begin
						state_reg <= SSIENC_SHIFT;
						tmr_reg   <= '0;
					end
				end
				SSIENC_SHIFT: begin
					if (frame_latch || !sclk_filt_reg) begin
						tmr_reg <= '0;
					end else if (tmr_reg == TMR_W'(TIMEOUT_CYC - 1)) begin
						state_reg    <= SSIENC_HOLD;
						link_rst_reg <= 1'b1;
					end else begin
						tmr_reg <= tmr_reg + TMR_W'(1);
					end
				end
				SSIENC_HOLD: begin
					state_reg <= SSIENC_IDLE;                      // Link reset pulse
				end
				default: state_reg <= SSIENC_IDLE;                 // Unused code recovers
			endcase
		end
	end

	// ==========================================================
	// Power-up availability delay
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			avail_cnt_reg <= '0;
			ready_reg     <= 1'b0;
		end else if (avail_cnt_reg == QUAL_W'(AVAIL_CYCLES - 1)) begin
			ready_reg     <= 1'b1;
		end else begin
			avail_cnt_reg <= avail_cnt_reg + QUAL_W'(1);
		end
	end

	// ==========================================================
	// Function inputs qualified for a fixed time, well inside 10 ms
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			dir_cnt_reg <= '0;
			dir_rev_reg <= 1'b0;
		end else if ((~dir_filt_reg) == dir_rev_reg) begin
			dir_cnt_reg <= '0;
		end else if (dir_cnt_reg == QUAL_W'(QUAL_CYCLES - 1)) begin
			dir_rev_reg <= ~dir_filt_reg;
			dir_cnt_reg <= '0;
		end else begin
			dir_cnt_reg <= dir_cnt_reg + QUAL_W'(1);
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			zero_cnt_reg  <= '0;
			zero_done_reg <= 1'b0;
		end else if (!zero_filt_reg) begin
			zero_cnt_reg  <= '0;
			zero_done_reg <= 1'b0;
		end else if (!zero_done_reg && zero_cnt_reg == QUAL_W'(QUAL_CYCLES - 1)) begin
			zero_done_reg <= 1'b1;
		end else if (!zero_done_reg) begin
			zero_cnt_reg  <= zero_cnt_reg + QUAL_W'(1);
		end
	end

	// ==========================================================
	// Position: raw count from sensor steps, offset from zero-set
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			raw_reg <= '0;
		end else if (step_dn_in && !step_up_in) begin
			raw_reg <= raw_reg - POS_BITS'(1);
		end else if (step_up_in && !step_dn_in) begin
			raw_reg <= raw_reg + POS_BITS'(1);
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			offset_reg <= '0;
		end else if (zero_filt_reg && !zero_done_reg &&
		             zero_cnt_reg == QUAL_W'(QUAL_CYCLES - 1)) begin
			offset_reg <= raw_reg;
		end
	end

	// Direction reverse flips the sign of the reported value
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pos_reg <= '0;
		end else begin
			pos_reg <= dir_rev_reg ? (offset_reg - raw_reg) : (raw_reg - offset_reg);
		end
	end

	// Word and ready frozen through a frame; sclk idles, so no link-side sync
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			word_reg       <= '0;
			ready_link_reg <= 1'b0;
		end else if (state_reg == SSIENC_IDLE && !frame_latch) begin
			word_reg       <= {ctrl_reg[CTRL_BINARY_BIT] ? pos_reg : to_gray(pos_reg),
			                   ctrl_reg[CTRL_SPECIAL_BIT]};
			ready_link_reg <= ready_reg;
		end
	end

	// ==========================================================
	// Link shifter, cleared by the timeout
	ssienc_link u_link (
		.sclk_in       (sclk_in),
		.rst_in        (~link_rst_n_reg),
		.word_in       (word_reg),
		.ready_in      (ready_link_reg),
		.data_out      (link_data),
		.frame_tgl_out (link_tgl)
	);

	// Data line back to core clock; output sits high when idle
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sdata_out <= 1'b1;
		end else begin
			sdata_out <= (state_reg == SSIENC_SHIFT) ? link_data : 1'b1;
		end
	end

	// ==========================================================
	// Incremental track: one quadrature step per N sensor steps
	always_comb begin
		unique case (ctrl_reg[CTRL_PPR_LSB +: 2])
			SSIENC_PPR_1024: sub_max = 12'h03f;
			SSIENC_PPR_2048: sub_max = 12'h01f;
			default:         sub_max = 12'h00f;
		endcase
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sub_reg  <= '0;
			quad_reg <= 2'h0;
		end else if (ctrl_reg[CTRL_INCR_EN_BIT] && (step_up_in ^ step_dn_in)) begin
			if (sub_reg >= sub_max) begin
				sub_reg  <= '0;
				quad_reg <= step_up_in ? {quad_reg[0], ~quad_reg[1]}
				                       : {~quad_reg[0], quad_reg[1]};
			end else begin
				sub_reg  <= sub_reg + 12'h001;
			end
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			track_a_out   <= 1'b0;
			track_a_n_out <= 1'b1;
			track_b_out   <= 1'b0;
			track_b_n_out <= 1'b1;
		end else begin
			track_a_out   <= quad_reg[1];
			track_a_n_out <= ~quad_reg[1];
			track_b_out   <= quad_reg[0];
			track_b_n_out <= ~quad_reg[0];
		end
	end

	// ==========================================================
	// Avalon slave: one wait cycle, then answer
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_reg         <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			ack_reg         <= (avs_read | avs_write) & ~ack_reg;
			avs_waitrequest <= ~((avs_read | avs_write) & ~ack_reg); // Inverse of ack, as a flop
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_reg <= CTRL_RESET;
		end else if (avs_write && ack_reg && avs_address == CTRL_ADDR) begin
			ctrl_reg <= {26'h0, avs_writedata[5:4], 1'b0, avs_writedata[2:0]};
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_readdata <= '0;
		end else if (avs_read && !ack_reg) begin
			unique case (avs_address)
				CTRL_ADDR: avs_readdata <= ctrl_reg;
				POS_ADDR:  avs_readdata <= {2'h0, pos_reg};
				STAT_ADDR: avs_readdata <= {27'h0, tgl_sync_reg[2], dir_rev_reg,
				                            zero_done_reg, state_reg == SSIENC_SHIFT, ready_reg};
				default:   avs_readdata <= '0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- dv/ssienc_ctrl_model.sv ----
// Partner: position controller that clocks serial frames out of the encoder
`timescale 1ns/1ns
`default_nettype none
module ssienc_ctrl_model (
	input  wire logic        lclk_in,  // Link base clock, 15 ns
	input  wire logic        go_in,    // Any toggle starts one frame
	input  wire logic [9:0]  half_in,  // Half bit period in lclk cycles
	input  wire logic        sdata_in, // Serial data from encoder
	output logic             sclk_out, // Serial clock burst
	output logic [30:0]      word_out, // Last word received
	output logic             done_out  // Toggles when a frame ends
);
	// ====
	// Burst engine: clock parks high between frames, so no stray edges
	initial begin
		sclk_out = 1'b1;
		word_out = '0;
		done_out = 1'b0;
		forever begin
			@(go_in);
			// One latch edge plus 31 data edges; sample on falls after the first
			for (int i = 0; i < 32; i++) begin
				repeat (half_in) @(posedge lclk_in);
				sclk_out <= 1'b0;
				if (i > 0) word_out <= {word_out[29:0], sdata_in};
				repeat (half_in) @(posedge lclk_in);
				sclk_out <= 1'b1;
			end
			done_out <= ~done_out;
		end
	end
endmodule
`default_nettype wire

// ---- dv/ssienc_top_assertions.sv ----
// Checker: port-level assertions for the serial encoder top
`timescale 1ns/1ns
`default_nettype none
module ssienc_top_checker
	import ssienc_pkg::*;
#(
	parameter int unsigned AVAIL_CYCLES = 100, // Power-up delay
	parameter int unsigned QUAL_CYCLES  = 20   // Input filter
)(
	input  wire logic        mclk_in,         // Core clock
	input  wire logic        rst_in,          // Reset
	input  wire logic        sclk_in,         // Serial clock
	input  wire logic        sdata_out,       // Serial data
	input  wire logic        track_a_out,     // Track A
	input  wire logic        track_a_n_out,   // Track A inverse
	input  wire logic        track_b_out,     // Track B
	input  wire logic        track_b_n_out,   // Track B inverse
	input  wire logic        avs_read,        // Bus read
	input  wire logic        avs_write,       // Bus write
	input  wire logic [31:0] avs_readdata,    // Bus read data
	input  wire logic        avs_waitrequest  // Bus wait
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// ====
	// Helpers: cycles of serial clock high, and a frame seen since idle
	logic [10:0] hi_cnt_reg;
	logic        seen_reg;
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) hi_cnt_reg <= 11'h000;
		else if (!sclk_in) hi_cnt_reg <= 11'h000;
		else if (hi_cnt_reg != 11'h7ff) hi_cnt_reg <= hi_cnt_reg + 11'h001;
	end
	// Cleared well past the timeout so the next idle stretch starts clean
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) seen_reg <= 1'b0;
		else if (!sclk_in) seen_reg <= 1'b1;
		else if (hi_cnt_reg == 11'h5dc) seen_reg <= 1'b0;
	end
	// ====
	// Assertions
	comp_a_a: assert property (track_a_n_out == !track_a_out)
		else $error("track A complement wrong");
	comp_b_a: assert property (track_b_n_out == !track_b_out)
		else $error("track B complement wrong");
	quad_step_a: assert property (!($changed(track_a_out) && $changed(track_b_out)))
		else $error("both tracks moved together");
	idle_high_a: assert property (hi_cnt_reg == 11'h44c |-> sdata_out)
		else $error("data not high after idle timeout");
	hold_low_a: assert property (seen_reg && hi_cnt_reg == 11'h190 |-> !sdata_out)
		else $error("data not low before timeout");
	wait_answer_a: assert property (($rose(avs_read) || $rose(avs_write))
		|-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer not one cycle");
	ans_pulse_a: assert property ((avs_read || avs_write) && !avs_waitrequest
		|=> avs_waitrequest) else $error("wait low for more than a cycle");
	rd_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data moved without a read");
	// Covers for the main scenarios
	cover property (seen_reg && hi_cnt_reg == 11'h190);
	cover property (avs_read && !avs_waitrequest);
	cover property ($changed(track_a_out));
endmodule
bind ssienc_top ssienc_top_checker #(
	.AVAIL_CYCLES(AVAIL_CYCLES), .QUAL_CYCLES(QUAL_CYCLES)
) ssienc_top_checker_i (
	.mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(sclk_in), .sdata_out(sdata_out),
	.track_a_out(track_a_out), .track_a_n_out(track_a_n_out),
	.track_b_out(track_b_out), .track_b_n_out(track_b_n_out),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest)
);
`default_nettype wire

// ---- dv/ssienc_top_tb.sv ----
// Testbench: encoder top with controller model and register bus master
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module ssienc_top_tb;
	import ssienc_pkg::*;
	localparam int unsigned AV = 100;
	localparam int unsigned QU = 20;
	logic        mclk_in = 1'b0;
	logic        lclk    = 1'b0;
	logic        rst_in  = 1'b1;
	logic        sclk, sdata, ta, tan, tb, tbn, wreq, done, pa, pb;
	logic        dir_n   = 1'b1;
	logic        zero    = 1'b0;
	logic        up      = 1'b0;
	logic        dn      = 1'b0;
	logic        rd      = 1'b0;
	logic        wr      = 1'b0;
	logic        go      = 1'b0;
	logic [3:0]  addr    = 4'h0;
	logic [31:0] wdata   = 32'h0;
	logic [31:0] rdata;
	logic [9:0]  half    = 10'h011;
	logic [30:0] word;
	logic [29:0] pos;
	logic [63:0] expq[$];
	int          bad_count = 0;
	int          total_checks = 0;
	int          seed = 34921;
	int          edges = 0;
	int          n, m, e0;
	// ====
	// Clocks: core 20 ns, link base 15 ns with its own phase
	always #10 mclk_in = ~mclk_in;
	always begin
		#7 lclk = 1'b1;
		#8 lclk = 1'b0;
	end
	ssienc_top #(.AVAIL_CYCLES(AV), .QUAL_CYCLES(QU)) ssienc_top_i (
		.mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(sclk), .sdata_out(sdata),
		.dir_sel_n_in(dir_n), .zero_set_in(zero), .step_up_in(up), .step_dn_in(dn),
		.track_a_out(ta), .track_a_n_out(tan), .track_b_out(tb), .track_b_n_out(tbn),
		.avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
		.avs_readdata(rdata), .avs_waitrequest(wreq));
	ssienc_ctrl_model ssienc_ctrl_model_i (
		.lclk_in(lclk), .go_in(go), .half_in(half), .sdata_in(sdata),
		.sclk_out(sclk), .word_out(word), .done_out(done));
	// ====
	// Tasks
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g);
		logic [63:0] x;
		x = expq.pop_front();
		`CHK(g & x[63:32], x[31:0])
	endtask
	// Request held until wait is sampled low, then released, one idle cycle
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		// No cycle limit here; only the watchdog ends a hung wait
		do begin
			@(posedge mclk_in);
		end while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic rdx(input logic [3:0] a, input logic [31:0] mk, input logic [31:0] e);
		expq.push_back({mk, e});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic steps(input logic u, input int k);
		repeat (k) begin
			@(posedge mclk_in);
			up <= u;
			dn <= !u;
			@(posedge mclk_in);
			up <= 1'b0;
			dn <= 1'b0;
		end
	endtask
	task automatic frame(input logic [9:0] h, input logic [30:0] e);
		expq.push_back({32'h7fffffff, 1'b0, e});
		@(posedge mclk_in);
		half <= h;
		go <= !go;
		@(done);
		repeat (10) @(posedge mclk_in);
		`CHK(sdata, 1'b0)
		// No new frame until data is back high
		repeat (1200) @(posedge mclk_in);
		`CHK(sdata, 1'b1)
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	// ====
	// Scoreboard: oldest note against each read or frame result
	always @(posedge mclk_in) begin
		if (rd === 1'b1 && wreq === 1'b0) chk(rdata);
	end
	always @(done) begin
		if ($time > 0) chk({1'b0, word});
	end
	// Track edge counter for the divider checks
	always @(posedge mclk_in) begin
		edges <= edges + int'(ta != pa) + int'(tb != pb);
		pa <= ta;
		pb <= tb;
	end
	// Watchdog well beyond the planned run
	initial begin
		repeat (100000) @(posedge mclk_in);
		bad_count++;
		report_and_stop();
	end
	// ====
	// Main sequence
	initial begin
		repeat (4) @(posedge mclk_in);
		`CHK({sdata, ta, tan, tb, tbn, wreq}, 6'h2b)
		repeat (4) @(posedge mclk_in);
		rst_in <= 1'b0;
		rdx(STAT_ADDR, 32'h1, 32'h0);
		repeat (AV + 10) @(posedge mclk_in);
		rdx(STAT_ADDR, 32'h1, 32'h1);
		tend("ready");
		steps(1'b1, 1 + ($random(seed) & 15));
		zero <= 1'b1;
		repeat (QU + 10) @(posedge mclk_in);
		// Applied flag clears with the input, so read it while still held
		rdx(STAT_ADDR, 32'h4, 32'h4);
		zero <= 1'b0;
		pos = '0;
		rdx(POS_ADDR, 32'h3fffffff, 32'h0);
		tend("zero");
		n = 1 + ($random(seed) & 31);
		m = 1 + ($random(seed) & 31);
		steps(1'b1, n);
		steps(1'b0, m);
		pos = pos + 30'(n) - 30'(m);
		rdx(POS_ADDR, 32'h3fffffff, {2'b00, pos});
		// Writes outside the control word must be ignored
		bus(1'b1, CTRL_ADDR, 32'h3);
		bus(1'b1, POS_ADDR, 32'hffffffff);
		rdx(CTRL_ADDR, 32'h37, 32'h3);
		rdx(POS_ADDR, 32'h3fffffff, {2'b00, pos});
		tend("registers");
		// Steps during the burst must not reach the latched word
		fork
			frame(10'h011, {pos, 1'b1});
			begin
				repeat (30) @(posedge mclk_in);
				steps(1'b1, 3);
			end
		join
		pos = pos + 30'h3;
		bus(1'b1, CTRL_ADDR, 32'h0);
		frame(10'h14d, {pos ^ (pos >> 1), 1'b0});
		tend("frames");
		dir_n <= 1'b0;
		repeat (QU + 10) @(posedge mclk_in);
		rdx(STAT_ADDR, 32'h8, 32'h8);
		n = 1 + ($random(seed) & 31);
		steps(1'b1, n);
		// Reversal mirrors the reported value, then up steps count down
		pos = 30'(0) - pos - 30'(n);
		rdx(POS_ADDR, 32'h3fffffff, {2'b00, pos});
		tend("direction");
		// Four divider spans give four track edges whatever the phase
		for (int c = 0; c < 3; c++) begin
			bus(1'b1, CTRL_ADDR, 32'h4 | (32'(c) << 4));
			e0 = edges;
			steps(1'b0, 4 * (64 >> c));
			repeat (4) @(posedge mclk_in);
			`CHK(edges - e0, 4)
		end
		tend("incremental");
		report_and_stop();
	end
endmodule
`default_nettype wire
